//--- shared/pkc_map.svh
// Register map constants for the peak capture and configuration bank.
// Assumes a word-wide register port driven by the device's serial front end.
//
// Contract
// - An all-zero filter bypass register leaves every high-pass filter enabled.
// - Any nonzero filter bypass register bypasses all high-pass filters together.
// - The current peak register carries the current peak magnitude in bits 23:0.
// - Current peak bits 24, 25, 26 mark phase A, B, C as the source of the peak.
// - Bits 31:27 of both peak registers always read as zero.
// - The voltage peak register carries the voltage peak magnitude in bits 23:0.
// - Voltage peak bits 24, 25, 26 mark phase A, B, C as the source of the peak.
// - Zero-padded 24- and 20-bit registers go out as 32 bits with 8 or 12 zero top bits.
// - A sign-extended 24-bit register goes out as 32 bits replicating its sign bit.
// - A zero-padded 10-bit register goes out as 32 bits with 22 zero top bits.
// - Signed registers are two's complement, unsigned ones plain binary.
// - The pulse-per-latch count sets pulses between energy latches and resets to one.
// - With the serial peripheral port active, accesses to 0xEBFF toggle the select pin.
// - In low power mode 2 the overcurrent threshold, reset 0x07, sets the detect level.
// - In low power mode 1 the mode-1 config register, reset 0x00, is applied.
`ifndef PKC_MAP_SVH
`define PKC_MAP_SVH
`define PKC_ADDR_HPF_DISABLE   16'h43B6
`define PKC_ADDR_CUR_PEAK      16'hE500
`define PKC_ADDR_VOLT_PEAK     16'hE501
`define PKC_ADDR_PULSE_LATCH   16'hE705
`define PKC_ADDR_FAST_CAPTURE  16'hE706
`define PKC_ADDR_DIE_VERSION   16'hE707
`define PKC_ADDR_CS_TOGGLE     16'hEBFF
`define PKC_ADDR_LP_OC_THRESH  16'hEC00
`define PKC_ADDR_LP_MODE1_CFG  16'hEC01
`define PKC_RST_HPF_DISABLE    24'h000000
`define PKC_RST_PEAK           27'h0000000
`define PKC_RST_PULSE_LATCH    8'h01
`define PKC_RST_FAST_CAPTURE   8'h00
`define PKC_RST_LP_OC_THRESH   8'h07
`define PKC_RST_LP_MODE1_CFG   8'h00
`define PKC_DIE_VERSION_VAL    8'h5A
`define PKC_PEAK_VAL_MSB       23
`define PKC_PEAK_PHASE_LSB     24
`define PKC_PEAK_PHASE_MSB     26
`define PKC_PEAK_PAD_BITS      5
`define PKC_ZERO_WORD          32'h00000000
`endif

//--- shared/pkc_pkg.sv
// Types shared by the peak capture and configuration bank.
// Assumes the constants header is included alongside.
package pkc_pkg;
  typedef enum logic [1:0] {
    PKC_PAD_ZERO24 = 2'b00,
    PKC_PAD_ZERO20 = 2'b01,
    PKC_PAD_SIGN24 = 2'b10,
    PKC_PAD_ZERO10 = 2'b11
  } pkc_pad_t;
  typedef enum logic [1:0] {
    PKC_PWR_NORMAL = 2'b00,
    PKC_PWR_MODE1  = 2'b01,
    PKC_PWR_MODE2  = 2'b10,
    PKC_PWR_SLEEP  = 2'b11
  } pkc_pwr_t;
endpackage

//--- hdl/pkc_regs.sv
// Peak capture, filter bypass and low power configuration register bank.
// Assumes a single-cycle register port from the serial front end, synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
`include "pkc_map.svh"
module pkc_regs (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [15:0]      reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire pkc_pkg::pkc_pad_t pad_mode,
  input  wire logic [31:0]      pad_in,
  input  wire logic             spi_active,
  input  wire pkc_pkg::pkc_pwr_t pwr_mode,
  input  wire logic             cur_peak_load,
  input  wire logic [23:0]      cur_peak_value,
  input  wire logic [2:0]       cur_peak_phase_flags,
  input  wire logic             volt_peak_load,
  input  wire logic [23:0]      volt_peak_value,
  input  wire logic [2:0]       volt_peak_phase_flags,
  output logic [31:0]           reg_rdata,
  output logic                  reg_rvalid,
  output logic [31:0]           pad_out,
  output logic                  hpf_bypass,
  output logic [7:0]            pulse_per_latch_count,
  output logic [7:0]            fast_capture_port_config,
  output logic                  oc_check_en,
  output logic [7:0]            oc_level,
  output logic                  mode1_cfg_en,
  output logic [7:0]            mode1_cfg,
  output logic                  chip_select_or_capture_ack_pin
);
  import pkc_pkg::*;

  logic [23:0] hpf_disable_reg;
  logic [26:0] cur_peak_reg;
  logic [26:0] volt_peak_reg;
  logic [7:0]  pulse_latch_reg;
  logic [7:0]  fast_capture_reg;
  logic [7:0]  oc_thresh_reg;
  logic [7:0]  mode1_cfg_reg;
  logic        cs_pin_reg;
  logic [31:0] rdata_next;

  // Widen a 27-bit peak word, top bits forced low
  function automatic logic [31:0] peak_word(input logic [26:0] p);
    peak_word = {{`PKC_PEAK_PAD_BITS{1'b0}}, p};
  endfunction

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction

  // Configuration registers, writable by the host
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hpf_disable_reg  <= `PKC_RST_HPF_DISABLE;
      pulse_latch_reg  <= `PKC_RST_PULSE_LATCH;
      fast_capture_reg <= `PKC_RST_FAST_CAPTURE;
      oc_thresh_reg    <= `PKC_RST_LP_OC_THRESH;
      mode1_cfg_reg    <= `PKC_RST_LP_MODE1_CFG;
    end else if (clk_en && reg_wr) begin
      unique case (reg_addr)
        `PKC_ADDR_HPF_DISABLE:  hpf_disable_reg  <= reg_wdata[23:0];
        `PKC_ADDR_PULSE_LATCH:  pulse_latch_reg  <= reg_wdata[7:0];
        `PKC_ADDR_FAST_CAPTURE: fast_capture_reg <= reg_wdata[7:0];
        `PKC_ADDR_LP_OC_THRESH: oc_thresh_reg    <= reg_wdata[7:0];
        `PKC_ADDR_LP_MODE1_CFG: mode1_cfg_reg    <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Peak capture, loaded only by the detector; host writes fall through
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_peak_reg  <= `PKC_RST_PEAK;
      volt_peak_reg <= `PKC_RST_PEAK;
    end else if (clk_en) begin
      if (cur_peak_load) begin
        cur_peak_reg <= {cur_peak_phase_flags, cur_peak_value};
      end
      if (volt_peak_load) begin
        volt_peak_reg <= {volt_peak_phase_flags, volt_peak_value};
      end
    end
  end

  // Select pin toggles on any access to the reserved slot, SPI only
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_pin_reg <= 1'b1;
    end else if (clk_en && spi_active && (reg_wr || reg_rd)
                 && reg_addr == `PKC_ADDR_CS_TOGGLE) begin
      cs_pin_reg <= ~cs_pin_reg;
    end
  end

  always_comb begin
    rdata_next = `PKC_ZERO_WORD;
    unique case (reg_addr)
      `PKC_ADDR_HPF_DISABLE:  rdata_next = {8'h00, hpf_disable_reg};
      `PKC_ADDR_CUR_PEAK:     rdata_next = peak_word(cur_peak_reg);
      `PKC_ADDR_VOLT_PEAK:    rdata_next = peak_word(volt_peak_reg);
      `PKC_ADDR_PULSE_LATCH:  rdata_next = byte_word(pulse_latch_reg);
      `PKC_ADDR_FAST_CAPTURE: rdata_next = byte_word(fast_capture_reg);
      `PKC_ADDR_DIE_VERSION:  rdata_next = byte_word(`PKC_DIE_VERSION_VAL);
      `PKC_ADDR_LP_OC_THRESH: rdata_next = byte_word(oc_thresh_reg);
      `PKC_ADDR_LP_MODE1_CFG: rdata_next = byte_word(mode1_cfg_reg);
      default:                rdata_next = `PKC_ZERO_WORD;
    endcase
  end

  // Read port, one cycle latency
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata  <= `PKC_ZERO_WORD;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // Link word formatter; unsigned inputs pass as plain binary
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pad_out <= `PKC_ZERO_WORD;
    end else if (clk_en) begin
      unique case (pad_mode)
        PKC_PAD_ZERO24: pad_out <= {8'h00, pad_in[23:0]};
        PKC_PAD_ZERO20: pad_out <= {12'h000, pad_in[19:0]};
        PKC_PAD_SIGN24: pad_out <= {{8{pad_in[23]}}, pad_in[23:0]};
        PKC_PAD_ZERO10: pad_out <= {16'h0000, 6'h00, pad_in[9:0]};
      endcase
    end
  end

  // Outputs to the datapath, all registered
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hpf_bypass               <= 1'b0;
      pulse_per_latch_count    <= `PKC_RST_PULSE_LATCH;
      fast_capture_port_config <= `PKC_RST_FAST_CAPTURE;
      oc_check_en              <= 1'b0;
      oc_level                 <= `PKC_RST_LP_OC_THRESH;
      mode1_cfg_en             <= 1'b0;
      mode1_cfg                <= `PKC_RST_LP_MODE1_CFG;
    end else if (clk_en) begin
      hpf_bypass               <= |hpf_disable_reg;
      pulse_per_latch_count    <= pulse_latch_reg;
      fast_capture_port_config <= fast_capture_reg;
      oc_check_en              <= (pwr_mode == PKC_PWR_MODE2);
      oc_level                 <= oc_thresh_reg;
      mode1_cfg_en             <= (pwr_mode == PKC_PWR_MODE1);
      mode1_cfg                <= mode1_cfg_reg;
    end
  end

  assign chip_select_or_capture_ack_pin = cs_pin_reg;
endmodule // pkc_regs
`default_nettype wire

//--- bench/pkc_regs_properties.sv
// Port assertions for the peak capture and config bank.
// Bound onto pkc_regs below.
`timescale 1ns/100ps
`default_nettype none
module pkc_regs_properties import pkc_pkg::*; (
  input wire logic              ref_clk, sys_rst, clk_en, reg_wr, reg_rd, spi_active,
  input wire logic [15:0]       reg_addr,
  input wire logic [31:0]       reg_wdata, pad_in, pad_out,
  input wire pkc_pkg::pkc_pad_t pad_mode,
  input wire logic              hpf_bypass, chip_select_or_capture_ack_pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic hw, cs, pe, pin;
  assign hw = clk_en && reg_wr && reg_addr == 16'h43B6;
  assign cs = clk_en && spi_active && (reg_wr || reg_rd) && reg_addr == 16'hEBFF;
  // Release edge still holds pad_out in reset
  assign pe = clk_en && !sys_rst;
  assign pin = chip_select_or_capture_ack_pin;
  AST_HPF_OFF: assert property (hw && !reg_wdata[23:0] ##1 clk_en |=> !hpf_bypass)
    else $error("bypass after zero");
  AST_HPF_ON: assert property (hw && |reg_wdata[23:0] ##1 clk_en |=> hpf_bypass)
    else $error("no bypass");
  AST_PAD_Z24: assert property (pe && pad_mode == PKC_PAD_ZERO24
    |=> pad_out == {8'h00, $past(pad_in[23:0])}) else $error("pad 24 bad");
  AST_PAD_Z20: assert property (pe && pad_mode == PKC_PAD_ZERO20
    |=> pad_out == {12'h000, $past(pad_in[19:0])}) else $error("pad 20 bad");
  AST_PAD_SE24: assert property (pe && pad_mode == PKC_PAD_SIGN24
    |=> pad_out == {{8{$past(pad_in[23])}}, $past(pad_in[23:0])}) else $error("sign bad");
  AST_PAD_Z10: assert property (pe && pad_mode == PKC_PAD_ZERO10
    |=> pad_out == {16'h0000, 6'h00, $past(pad_in[9:0])}) else $error("pad 10 bad");
  AST_CS_FLIP: assert property (cs |=> $changed(pin)) else $error("no toggle");
  AST_CS_HOLD: assert property (!cs |=> $stable(pin)) else $error("pin moved");
endmodule // pkc_regs_properties
bind pkc_regs pkc_regs_properties u_props (.*);
`default_nettype wire

//--- bench/pkc_host_model.sv
// Host side of the register port, one access at a time.
// Assumes a read answer one edge after the strobe is taken.
`timescale 1ns/100ps
`default_nettype none
module pkc_host_model (
  input  wire logic        ref_clk, reg_rvalid,
  input  wire logic [31:0] reg_rdata,
  output logic             reg_wr, reg_rd,
  output logic [15:0]      reg_addr,
  output logic [31:0]      reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 50'h0;
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    // Released bus inverted so a stale value never matches
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b0, ~a};
    @(posedge ref_clk) d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hXXXXXXXX;
  endtask
endmodule // pkc_host_model
`default_nettype wire

//--- bench/pkc_regs_tb_top.sv
// Bench top: reset values, writes, peak loads, formatter and power mode.
// Assumes the bank, host model and bound checker compile alongside.
`timescale 1ns/100ps
`default_nettype none
module pkc_regs_tb_top;
  import pkc_pkg::*;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, spi_active = 1'b0;
  logic        cur_peak_load = 1'b0, volt_peak_load = 1'b0, chip_select_or_capture_ack_pin;
  logic        reg_wr, reg_rd, reg_rvalid, hpf_bypass, oc_check_en, mode1_cfg_en;
  logic [2:0]  cur_peak_phase_flags = 3'h0, volt_peak_phase_flags = 3'h0;
  logic [23:0] cur_peak_value = 24'h0, volt_peak_value = 24'h0;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, pad_out, d, pad_in = 32'hFF8ABCDE;
  logic [7:0]  pulse_per_latch_count, fast_capture_port_config, oc_level, mode1_cfg;
  pkc_pad_t    pad_mode = PKC_PAD_ZERO24;
  pkc_pwr_t    pwr_mode = PKC_PWR_NORMAL;
  int          n_mismatch = 0, check_count = 0, cyc = 0;
  logic [15:0] addr_t [6] = '{16'hE705, 16'hE706, 16'hEC00, 16'hEC01, 16'h43B6, 16'hE501};
  logic [31:0] exp_t [6] = '{32'h1, 32'h0, 32'h7, 32'h0, 32'h0, 32'h0};
  logic [31:0] fmt_t [4] = '{32'h008ABCDE, 32'h000ABCDE, 32'hFF8ABCDE, 32'h000000DE};
  pkc_regs u_dut (.*);
  pkc_host_model u_host (.*);
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc > 3000) begin
    n_mismatch++;
    summarize();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp) n_mismatch++;
  endtask
  task automatic summarize();
    $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (addr_t[i]) begin
      u_host.rd(addr_t[i], d);
      chk(d, exp_t[i]);
    end
    u_host.wr(16'h43B6, 32'h00800000);
    u_host.wr(16'hE705, 32'h000000A5);
    repeat (2) @(posedge ref_clk) #1;
    chk({23'h0, hpf_bypass, pulse_per_latch_count}, 32'h1A5);
    @(posedge ref_clk);
    {cur_peak_value, cur_peak_phase_flags, cur_peak_load} <= {24'hABCDEF, 3'h4, 1'b1};
    {volt_peak_value, volt_peak_phase_flags, volt_peak_load} <= {24'h123456, 3'h1, 1'b1};
    @(posedge ref_clk) {cur_peak_load, volt_peak_load} <= 2'b00;
    u_host.wr(16'hE500, 32'hFFFFFFFF);
    u_host.rd(16'hE500, d);
    chk(d, 32'h04ABCDEF);
    u_host.rd(16'hE501, d);
    chk(d, 32'h01123456);
    spi_active <= 1'b1;
    u_host.rd(16'hEBFF, d);
    chk({d[31:1], chip_select_or_capture_ack_pin}, 32'h0);
    u_host.wr(16'h43B6, 32'h0);
    foreach (fmt_t[m]) begin
      @(posedge ref_clk) pad_mode <= pkc_pad_t'(m);
      repeat (2) @(posedge ref_clk) #1;
      chk(pad_out, fmt_t[m]);
    end
    @(posedge ref_clk) pwr_mode <= PKC_PWR_MODE2;
    repeat (2) @(posedge ref_clk) #1;
    chk({22'h0, hpf_bypass, oc_check_en, oc_level}, 32'h107);
    u_host.wr(16'hE706, 32'h0000005C);
    u_host.wr(16'hEC01, 32'h0000003C);
    @(posedge ref_clk) pwr_mode <= PKC_PWR_MODE1;
    repeat (2) @(posedge ref_clk) #1;
    chk({14'h0, oc_check_en, mode1_cfg_en, fast_capture_port_config, mode1_cfg},
        32'h00015C3C);
    // Frozen clock enable must swallow the write
    @(posedge ref_clk) clk_en <= 1'b0;
    u_host.wr(16'hEC00, 32'h00000033);
    clk_en <= 1'b1;
    u_host.rd(16'hEC00, d);
    chk(d, 32'h00000007);
    // Select pin must not move with the serial port inactive
    spi_active <= 1'b0;
    u_host.rd(16'hEBFF, d);
    chk({d[31:1], chip_select_or_capture_ack_pin}, 32'h0);
    summarize();
  end
endmodule // pkc_regs_tb_top
`default_nettype wire
